// ==== rtl/tlp_pin_interface.sv ====
`timescale 1ns/1ps
`include "tlp_cfg.svh"
// Notes on behaviour
// - Master reference clock drives recovery and attenuator.
// - Transmit formatter clocked by selected line clock.
// - Bipolar transmit data sampled on falling edge.
// - NRZ transmit data sampled on falling edge.
// - Error strobe edge flips one pattern bit.
// - Violation strobe edge inserts one violation.
// - Control select low hardware, high serial.
// - Output disable high tristates every output.
// - Receive data edge chosen by edge bit in serial bipolar mode.
// - NRZ violation flag high one recovered cycle.
// - NRZ data on positive, errors on negative.
// - Recovered clock follows master without signal.
// - Attenuator pin selects path, ignored serially.
// - Carrier loss output follows loss condition.
// - Pattern flag high searching, half-cycle error pulse.
// - Shared pins change role with mode.
// - Serial mode repurposes hardware control pins.
// - Serial input sampled on rising serial clock.
// - Serial output edge select, off unless reading.
// - Interrupt asserted in serial mode while any status bit set.
module tlp_pin_interface (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic master_clock,
    input wire logic tx_line_clock,
    input wire logic [1:0] txClockSource,
    input wire logic tx_positive_data,
    input wire logic tx_negative_data,
    input wire logic control_select,
    input wire logic output_disable_mode,
    input wire logic nrzMode,
    input wire logic patternEnable,
    input wire logic recoveredClock,
    input wire logic signalPresent,
    input wire logic rxLinePosBit,
    input wire logic rxLineNegBit,
    input wire logic rxViolationEvent,
    input wire logic carrierLoss,
    input wire logic patternSearching,
    input wire logic patternBitError,
    input wire logic rx_edge_select_bit,
    input wire logic nrz_enable_bit,
    input wire logic jaSelDriven,
    input wire logic jaSelLevel,
    input wire logic [1:0] jaSelSoftware,
    input wire logic serialChipSelN,
    input wire logic serialClock,
    input wire logic serial_in,
    input wire logic serial_edge_select,
    input wire logic serialReadActive,
    input wire logic serialReadBit,
    input wire logic [7:0] statusBits,
    output logic txClockOut,
    output logic txLinePos,
    output logic txLineNeg,
    output logic txLineOe,
    output logic [1:0] jaPath,
    output logic rxRefClock,
    output logic rx_positive_data,
    output logic rx_negative_data,
    output logic rxDataOe,
    output logic rxClockOut,
    output logic rxClockOe,
    output logic carrier_loss_flag,
    output logic pattern_detect_flag,
    output logic flagOe,
    output logic serial_out,
    output logic serialOutOe,
    output logic interruptN,
    output logic interruptOe,
    output logic [`TLP_SERIAL_WIDTH-1:0] serialShiftWord,
    output logic serialWordValid,
    output logic hardwareMode,
    output logic syncedSerialMode
);
    import tlp_pkg::*;

    // Transmit clock source; glitch-free switching is left to the clock tree
    logic txClk;
    assign txClk = (txClockSource == `TLP_TXSRC_MASTER) ? master_clock :
                   (txClockSource == `TLP_TXSRC_RECOVERED) ? recoveredClock :
                   tx_line_clock;
    assign txClockOut = txClk;
    assign rxRefClock = master_clock;

    // Mode levels brought into the transmit domain
    logic txNrz;
    logic txPat;
    logic txMs1;
    logic txMs2;
    logic txMp1;
    logic txMp2;
    always_ff @(negedge txClk) begin
        txMs1 <= nrzMode;
        txMs2 <= txMs1;
        txMp1 <= patternEnable;
        txMp2 <= txMp1;
    end
    assign txNrz = txMs2;
    assign txPat = txMp2;

    // Falling-edge samples of the transmit pins
    logic posSample_q;
    logic negSample_q;
    logic posPrev_q;
    logic negPrev_q;
    always_ff @(negedge txClk) begin
        posSample_q <= tx_positive_data;
        negSample_q <= tx_negative_data;
        posPrev_q <= posSample_q;
        negPrev_q <= negSample_q;
    end

    logic errEdge;
    logic bpvEdge;
    assign errEdge = posSample_q & ~posPrev_q & txPat;
    assign bpvEdge = negSample_q & ~negPrev_q & txNrz;

    // Test pattern generator, one bit flipped per strobe edge
    logic [19:0] prbs_q;
    logic prbsBit;
    assign prbsBit = prbs_q[19] ^ prbs_q[16];
    always_ff @(negedge txClk) begin
        if (!txPat) begin
            prbs_q <= `TLP_QRSS_SEED;
        end else begin
            prbs_q <= {prbs_q[18:0], prbsBit};
        end
    end

    // Line formatter: alternate mark inversion, violation repeats the polarity
    logic markPol_q;
    logic txPos_q;
    logic txNeg_q;
    logic nrzBit;
    logic markNow;
    logic polNow;
    assign nrzBit = txPat ? (prbsBit ^ errEdge) : posSample_q;
    assign markNow = nrzBit;
    assign polNow = bpvEdge ? markPol_q : ~markPol_q;
    always_ff @(negedge txClk) begin
        if (txNrz || txPat) begin
            txPos_q <= markNow & polNow;
            txNeg_q <= markNow & ~polNow;
            if (markNow) begin
                markPol_q <= polNow;
            end
        end else begin
            txPos_q <= posSample_q;
            txNeg_q <= negSample_q;
            // Known polarity before the first NRZ mark
            markPol_q <= 1'b0;
        end
    end
    assign txLinePos = txPos_q;
    assign txLineNeg = txNeg_q;

    // Mode decoding in the core domain
    logic ctrlSync;
    logic disSync;
    tlp_sync3 #(.WIDTH(2)) uModeSync (
        .clk(core_clk),
        .rst(rst),
        .asyncIn({control_select, output_disable_mode}),
        .syncOut({ctrlSync, disSync})
    );
    logic hwMode_q;
    logic outEn_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hwMode_q <= 1'b1;
            outEn_q <= 1'b0;
        end else begin
            hwMode_q <= ~ctrlSync;
            outEn_q <= ~disSync;
        end
    end
    assign hardwareMode = hwMode_q;
    assign syncedSerialMode = ~hwMode_q;

    // Attenuator path; floating pin seen as not driven
    assign jaPath = !hwMode_q ? jaSelSoftware :
                    !jaSelDriven ? `TLP_JA_OFF :
                    jaSelLevel ? `TLP_JA_RX : `TLP_JA_TX;

    // Receive side in the recovered clock domain
    logic rxEdgeEff;
    assign rxEdgeEff = rx_edge_select_bit & control_select;
    logic rxNrzEff;
    assign rxNrzEff = nrzMode | nrz_enable_bit;
    logic rx_positive_data_q;
    logic rx_negative_data_q;
    logic rPosF_q;
    logic rNegF_q;
    always_ff @(posedge recoveredClock) begin
        rx_positive_data_q <= rxNrzEff ? (rxLinePosBit | rxLineNegBit) : rxLinePosBit;
        rx_negative_data_q <= rxNrzEff ? rxViolationEvent : rxLineNegBit;
    end
    always_ff @(negedge recoveredClock) begin
        rPosF_q <= rx_positive_data_q;
        rNegF_q <= rx_negative_data_q;
    end
    assign rx_positive_data = (rxEdgeEff && !rxNrzEff) ? rPosF_q : rx_positive_data_q;
    assign rx_negative_data = (rxEdgeEff && !rxNrzEff) ? rNegF_q : rx_negative_data_q;
    assign rxClockOut = signalPresent ? recoveredClock : master_clock;

    // Pattern flag: searching level, error held for the high half only
    assign carrier_loss_flag = carrierLoss;
    assign pattern_detect_flag = patternEnable &
        (patternSearching | (patternBitError & recoveredClock));

    // Output enables
    assign txLineOe = outEn_q;
    assign rxDataOe = outEn_q;
    assign rxClockOe = outEn_q;
    assign flagOe = outEn_q;

    // Serial port, serial clock domain
    logic [`TLP_SERIAL_WIDTH-1:0] shift_q;
    logic [4:0] bitCnt_q;
    tlp_ser_state_t serState_q;
    tlp_ser_state_t serState_d;
    logic wordDone;
    assign wordDone = (bitCnt_q == 5'(`TLP_SERIAL_WIDTH - 1));
    always_comb begin
        case (serState_q)
            TLP_SER_IDLE: serState_d = TLP_SER_SHIFT;
            TLP_SER_SHIFT: serState_d = wordDone ? TLP_SER_DONE : TLP_SER_SHIFT;
            TLP_SER_DONE: serState_d = TLP_SER_SHIFT;
            default: serState_d = TLP_SER_IDLE;
        endcase
    end
    // Chip select acts as the asynchronous frame end of the serial domain
    always_ff @(posedge serialClock or posedge serialChipSelN) begin
        if (serialChipSelN) begin
            shift_q <= '0;
            bitCnt_q <= 5'h00;
            serState_q <= TLP_SER_IDLE;
        end else begin
            shift_q <= {shift_q[`TLP_SERIAL_WIDTH-2:0], serial_in};
            bitCnt_q <= wordDone ? 5'h00 : bitCnt_q + 5'h01;
            serState_q <= serState_d;
        end
    end

    // Word handed to core by toggle
    logic [`TLP_SERIAL_WIDTH-1:0] word_q;
    logic wordTog_q;
    always_ff @(posedge serialClock) begin
        if (!serialChipSelN && wordDone) begin
            word_q <= {shift_q[`TLP_SERIAL_WIDTH-2:0], serial_in};
        end
    end
    // Serial clock idles in reset, so the toggle clears asynchronously
    always_ff @(posedge serialClock or posedge rst) begin
        if (rst) begin
            wordTog_q <= 1'b0;
        end else if (!serialChipSelN && wordDone) begin
            wordTog_q <= ~wordTog_q;
        end
    end
    logic togSync;
    logic togSeen_q;
    logic [`TLP_SERIAL_WIDTH-1:0] wordOut_q;
    logic wordValid_q;
    tlp_sync3 #(.WIDTH(1)) uTogSync (
        .clk(core_clk),
        .rst(rst),
        .asyncIn(wordTog_q),
        .syncOut(togSync)
    );
    always_ff @(posedge core_clk) begin
        if (rst) begin
            togSeen_q <= 1'b0;
            wordOut_q <= '0;
            wordValid_q <= 1'b0;
        end else begin
            togSeen_q <= togSync;
            wordValid_q <= (togSync != togSeen_q) && !hwMode_q;
            if (togSync != togSeen_q) begin
                wordOut_q <= word_q;
            end
        end
    end
    assign serialShiftWord = wordOut_q;
    assign serialWordValid = wordValid_q;

    // Serial output launched on the chosen edge
    logic sdoR_q;
    logic sdoF_q;
    always_ff @(posedge serialClock) begin
        sdoR_q <= serialReadBit;
    end
    always_ff @(negedge serialClock) begin
        sdoF_q <= serialReadBit;
    end
    assign serial_out = serial_edge_select ? sdoF_q : sdoR_q;
    assign serialOutOe = outEn_q & ~hwMode_q & ~serialChipSelN & serialReadActive;

    // Interrupt: open-drain low in serial mode while status has a set bit
    assign interruptN = 1'b0;
    assign interruptOe = outEn_q & ~hwMode_q & (|statusBits);
endmodule

// ==== rtl/tlp_cfg.svh ====
`ifndef TLP_CFG_SVH
`define TLP_CFG_SVH
`define TLP_LINE_FREQ_KHZ 1544
`define TLP_CORE_FREQ_KHZ 125000
`define TLP_TXSRC_PIN 2'h0
`define TLP_TXSRC_MASTER 2'h1
`define TLP_TXSRC_RECOVERED 2'h2
`define TLP_JA_TX 2'h0
`define TLP_JA_RX 2'h1
`define TLP_JA_OFF 2'h2
`define TLP_QRSS_POLY_TAP 5'h10
`define TLP_QRSS_SEED 20'hFFFFF
`define TLP_SERIAL_WIDTH 16
`endif

// ==== rtl/tlp_pkg.sv ====
package tlp_pkg;
    typedef enum logic [1:0] {
        TLP_JA_TX_T = 2'h0,
        TLP_JA_RX_T = 2'h1,
        TLP_JA_OFF_T = 2'h2
    } tlp_ja_t;
    typedef enum logic [2:0] {
        TLP_SER_IDLE = 3'b001,
        TLP_SER_SHIFT = 3'b010,
        TLP_SER_DONE = 3'b100
    } tlp_ser_state_t;
endpackage

// ==== rtl/tlp_sync3.sv ====
`timescale 1ns/1ps
module tlp_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;
    // A change counts only once second and third stage agree
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else begin
            s1_q <= asyncIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
        end
    end
    assign syncOut = out_q;
endmodule

// ==== verif/tlp_pin_interface_chk.sv ====
`timescale 1ns/1ps
module tlp_pin_interface_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic control_select,
    input wire logic output_disable_mode,
    input wire logic carrierLoss,
    input wire logic jaSelDriven,
    input wire logic jaSelLevel,
    input wire logic [1:0] jaSelSoftware,
    input wire logic [7:0] statusBits,
    input wire logic [1:0] jaPath,
    input wire logic txLineOe,
    input wire logic rxDataOe,
    input wire logic interruptOe,
    input wire logic carrier_loss_flag,
    input wire logic serialWordValid,
    input wire logic hardwareMode,
    input wire logic syncedSerialMode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Mode needs a settled cycle before the pin path is trusted
    a_ja_pin: assert property (hardwareMode && $past(hardwareMode) |->
        jaPath == (jaSelDriven ? {1'b0, jaSelLevel} : 2'h2)) else $error("ja pin path");
    a_ja_soft: assert property (!hardwareMode && !$past(hardwareMode) |->
        jaPath == jaSelSoftware) else $error("ja soft path");
    a_all_off: assert property (output_disable_mode [*8] |->
        !(txLineOe || rxDataOe || interruptOe)) else $error("outputs on");
    a_carrier_flag: assert property (carrier_loss_flag == carrierLoss)
        else $error("carrier flag");
    a_word_once: assert property (serialWordValid |=> !serialWordValid)
        else $error("word pulse long");
    a_hw_refuse: assert property (hardwareMode [*8] |-> !serialWordValid)
        else $error("word in hw mode");
    a_mode_select: assert property (control_select [*8] |->
        syncedSerialMode && !hardwareMode) else $error("mode select");
    a_int_alert: assert property ((syncedSerialMode && !output_disable_mode
        && statusBits != 8'h00) [*8] |-> interruptOe) else $error("no interrupt");
    cover property (serialWordValid);
    cover property (interruptOe);
    cover property (output_disable_mode [*8]);
endmodule
bind tlp_pin_interface tlp_pin_interface_chk u_chk (.*);

// ==== verif/tlp_framer_model.sv ====
`timescale 1ns/1ps
module tlp_framer_model (
    output logic txClk,
    output logic txPos,
    output logic txNeg,
    input wire logic [15:0] posWord,
    input wire logic [15:0] negWord,
    input wire logic lineP,
    input wire logic lineN,
    input wire logic clrCnt,
    output logic [15:0] capP,
    output logic [15:0] capN,
    output logic [7:0] repeatCnt
);
    logic [3:0] idx = 4'h0;
    logic [3:0] prevIdx = 4'h0;
    logic lastPol = 1'b0;
    initial begin
        {txClk, txPos, txNeg} = 3'h0;
        #13 forever #32 txClk = ~txClk;
    end
    // Change on rising edge, so bits sit still around the falling sample
    always @(posedge txClk) begin
        txPos <= posWord[idx];
        txNeg <= negWord[idx];
        idx <= idx + 4'h1;
    end
    // Line bit seen at a falling edge was sampled two edges earlier
    always @(negedge txClk) begin
        capP[prevIdx] <= lineP;
        capN[prevIdx] <= lineN;
        prevIdx <= idx - 4'h2;
        if (clrCnt) repeatCnt <= 8'h00;
        else if ((lineP || lineN) && lineP == lastPol) repeatCnt <= repeatCnt + 8'h01;
        if (lineP || lineN) lastPol <= lineP;
    end
endmodule

// ==== verif/tlp_pin_interface_bench.sv ====
`timescale 1ns/1ps
module tlp_pin_interface_bench;
    logic rst, serialChipSelN = 1'b1, clrCnt = 1'b1, signalPresent = 1'b1;
    logic control_select = '0, output_disable_mode = '0, nrzMode = '0, patternEnable = '0;
    logic rxLinePosBit = '0, rxLineNegBit = '0, rxViolationEvent = '0, carrierLoss = '0;
    logic patternSearching = '0, patternBitError = '0, rx_edge_select_bit = '0;
    logic nrz_enable_bit = '0, jaSelDriven = '0, jaSelLevel = '0, serialClock = '0;
    logic serial_in = '0, serial_edge_select = '0, serialReadActive = '0, serialReadBit = '0;
    logic [1:0] txClockSource = '0, jaSelSoftware = '0;
    logic [7:0] statusBits = '0;
    logic [15:0] posWord = '0, negWord = '0;
    logic core_clk, master_clock, tx_line_clock, tx_positive_data, tx_negative_data;
    logic txClockOut, txLinePos, txLineNeg, txLineOe, rxRefClock, rx_positive_data;
    logic rx_negative_data, rxDataOe, rxClockOut, rxClockOe, carrier_loss_flag, flagOe;
    logic pattern_detect_flag, serial_out, serialOutOe, interruptN, interruptOe;
    logic serialWordValid, hardwareMode, syncedSerialMode, recoveredClock;
    logic [1:0] jaPath;
    logic [7:0] repeatCnt;
    logic [15:0] serialShiftWord, capP, capN, lastWord;
    int error_cnt = 0;
    int n_tests = 0;
    int words = 0;
    int i;
    assign recoveredClock = tx_line_clock;
    tlp_pin_interface DUT (.*);
    tlp_framer_model FRM (.txClk(tx_line_clock), .txPos(tx_positive_data),
        .txNeg(tx_negative_data), .posWord, .negWord, .lineP(txLinePos), .lineN(txLineNeg),
        .clrCnt, .capP, .capN, .repeatCnt);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        master_clock = 1'b0;
        forever #324 master_clock = ~master_clock;
    end
    always @(posedge core_clk) if (serialWordValid === 1'b1) begin
        words++;
        lastWord = serialShiftWord;
    end
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task send(input logic [15:0] w);
        serialChipSelN <= 1'b0;
        for (int k = 15; k >= 0; k--) begin
            tick(4);
            serial_in <= w[k];
            serialClock <= 1'b0;
            tick(4);
            serialClock <= 1'b1;
        end
        tick(4);
        {serialChipSelN, serialClock, serial_in} <= {2'h2, ~w[0]};
    endtask
    task summarize;
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        tick(5000);
        error_cnt++;
        summarize();
    end
    initial begin
        rst <= 1'b1;
        tick(5);
        rst <= 1'b0;
        tick(10);
        posWord <= 16'hC3A5;
        negWord <= 16'h0C52;
        tick(320);
        chk(capP, 16'hC3A5);
        chk(capN, 16'h0C52);
        nrzMode <= 1'b1;
        posWord <= 16'hFFFF;
        negWord <= 16'h0000;
        tick(160);
        clrCnt <= 1'b0;
        tick(160);
        chk(capP | capN, 16'hFFFF);
        chk(repeatCnt, 16'h0000);
        // Strobe held high afterwards: one edge, so one violation only
        negWord <= 16'hFFFF;
        tick(320);
        chk(repeatCnt, 16'h0001);
        nrzMode <= 1'b0;
        rxLinePosBit <= 1'b1;
        tick(40);
        chk({rx_positive_data, rx_negative_data}, 16'h0002);
        {rxLinePosBit, rxLineNegBit, carrierLoss, patternSearching, patternEnable} <= 5'h0F;
        tick(40);
        chk({rx_positive_data, rx_negative_data}, 16'h0001);
        chk({carrier_loss_flag, pattern_detect_flag}, 16'h0003);
        {nrz_enable_bit, rxViolationEvent} <= 2'h3;
        tick(40);
        chk({rx_positive_data, rx_negative_data}, 16'h0003);
        {nrz_enable_bit, rxViolationEvent} <= 2'h0;
        for (i = 0; i < 3; i++) begin
            {jaSelDriven, jaSelLevel} <= (i == 2) ? 2'h0 : {1'b1, i[0]};
            tick(2);
            chk(jaPath, 16'(i));
        end
        output_disable_mode <= 1'b1;
        tick(10);
        chk({txLineOe, rxDataOe, rxClockOe, flagOe, serialOutOe, interruptOe}, 16'h0);
        {output_disable_mode, control_select} <= 2'h1;
        tick(10);
        chk({txLineOe, rxDataOe, rxClockOe, flagOe, syncedSerialMode}, 16'h001F);
        for (i = 0; i < 3; i++) begin
            jaSelSoftware <= i[1:0];
            tick(2);
            chk(jaPath, 16'(i));
        end
        rx_edge_select_bit <= 1'b1;
        tick(2);
        rxLinePosBit <= 1'b1;
        @(posedge tx_line_clock);
        #2;
        chk(rx_positive_data, 16'h0000);
        @(negedge tx_line_clock);
        #2;
        chk(rx_positive_data, 16'h0001);
        tick(1);
        send(16'hB36C);
        statusBits <= 8'h04;
        tick(20);
        chk(lastWord, 16'hB36C);
        chk(16'(words), 16'h0001);
        chk(interruptOe, 16'h0001);
        {serialChipSelN, serialReadActive, serialReadBit} <= 3'h3;
        tick(2);
        chk(serialOutOe, 16'h0001);
        serialClock <= 1'b1;
        tick(2);
        chk(serial_out, 16'h0001);
        {serial_edge_select, serialReadBit} <= 2'h2;
        tick(2);
        serialClock <= 1'b0;
        tick(2);
        chk(serial_out, 16'h0000);
        {serialChipSelN, serialReadActive} <= 2'h2;
        {patternSearching, patternBitError, signalPresent} <= 3'h2;
        tick(2);
        chk(serialOutOe, 16'h0000);
        #2;
        chk({rxRefClock, rxClockOut}, {master_clock, master_clock});
        chk(txClockOut, tx_line_clock);
        chk(pattern_detect_flag, tx_line_clock);
        tick(1);
        txClockSource <= 2'h1;
        tick(1);
        #2;
        chk(txClockOut, master_clock);
        summarize();
    end
endmodule
